// ==== verilog/cwc_top.sv ====
// Function
// - complementary output enable bit 6 passes the complementary output to its pin
// - primary output enable bit 5 passes the primary output to its pin
// - primary invert bit 3 inverts the primary output when set
// - complementary invert bit 4 inverts the complementary output when set
// - bits 2 and 1 of control zero read zero, writes ignored
// - dead band counts generator clock periods from zero up to the count
// - invert bits do not touch the shutdown override levels
`timescale 1ns/1ns
module cwc_top (
  input wire logic mclk, // system clock, 10 MHz
  input wire logic rst, // asynchronous reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic source_in, // input source waveform
  input wire logic fast_osc_tick, // fast internal oscillator period pulse
  input wire logic shutdown_in, // external shutdown, active high level
  output logic primary_output, // primary output pin level
  output logic primary_output_oe, // primary pin driven
  output logic complementary_output, // complementary output pin level
  output logic complementary_output_oe // complementary pin driven
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic [cwc_pkg::DB_W-1:0] dbr;
    logic [cwc_pkg::DB_W-1:0] dbf;
    logic [2:0] shut;
    cwc_pkg::cwc_state_e state;
    logic src_q;
    logic ack;
    logic [31:0] dat;
    logic pa;
    logic pa_oe;
    logic pb;
    logic pb_oe;
  } cwc_top_s;

  cwc_top_s r;
  cwc_top_s next_r;
  logic tick;
  logic rise_edge;
  logic fall_edge;
  logic shut_req;
  logic enabled;
  logic rise_done;
  logic fall_done;
  logic rise_start;
  logic fall_start;
  logic bus_req;

  assign enabled = r.ctrl[cwc_pkg::CTRL_EN];
  // generator clock: fast oscillator pulse or every system clock
  assign tick = r.ctrl[cwc_pkg::CTRL_CS] ? fast_osc_tick : 1'b1;
  assign rise_edge = source_in && !r.src_q;
  assign fall_edge = !source_in && r.src_q;
  assign shut_req = r.shut[cwc_pkg::SHUT_SW] || shutdown_in;
  assign bus_req = wb_cyc_i && wb_stb_i && !r.ack;
  assign rise_start = (next_r.state == cwc_pkg::ST_RISE) &&
                      (r.state != cwc_pkg::ST_RISE);
  assign fall_start = (next_r.state == cwc_pkg::ST_FALL) &&
                      (r.state != cwc_pkg::ST_FALL);

  cwc_deadband u_rise (
    .mclk(mclk),
    .rst(rst),
    .start(rise_start),
    .tick(tick),
    .limit(r.dbr),
    .done(rise_done)
  );

  cwc_deadband u_fall (
    .mclk(mclk),
    .rst(rst),
    .start(fall_start),
    .tick(tick),
    .limit(r.dbf),
    .done(fall_done)
  );

  always_comb begin
    next_r = r;
    next_r.ack = 1'b0;
    next_r.src_q = source_in;
    // register slave: one-cycle answer, unmapped reads zero
    if (bus_req) begin
      next_r.ack = 1'b1;
      next_r.dat = '0;
      case (wb_adr_i)
        cwc_pkg::ADR_CTRL: begin
          next_r.dat[7:0] = r.ctrl;
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.ctrl = wb_dat_i[7:0] & cwc_pkg::CTRL_MASK;
          end
        end
        cwc_pkg::ADR_DB_RISE: begin
          next_r.dat[cwc_pkg::DB_W-1:0] = r.dbr;
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.dbr = wb_dat_i[cwc_pkg::DB_W-1:0];
          end
        end
        cwc_pkg::ADR_DB_FALL: begin
          next_r.dat[cwc_pkg::DB_W-1:0] = r.dbf;
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.dbf = wb_dat_i[cwc_pkg::DB_W-1:0];
          end
        end
        cwc_pkg::ADR_SHUT: begin
          next_r.dat[2:0] = r.shut;
          if (wb_we_i && wb_sel_i[0]) begin
            next_r.shut = wb_dat_i[2:0];
          end
        end
        cwc_pkg::ADR_STATUS: begin
          next_r.dat[7:0] = {r.pb, r.pa, r.state};
        end
        default: begin
          next_r.dat = '0;
        end
      endcase
    end

    // waveform sequencer
    case (r.state)
      cwc_pkg::ST_OFF: begin
        next_r.state = source_in ? cwc_pkg::ST_RISE : cwc_pkg::ST_FALL;
      end
      cwc_pkg::ST_SHUT: begin
        if (!shut_req && rise_edge) begin
          next_r.state = cwc_pkg::ST_RISE;
        end
      end
      cwc_pkg::ST_RISE: begin
        if (fall_edge) begin
          next_r.state = cwc_pkg::ST_FALL;
        end else if (rise_done) begin
          next_r.state = cwc_pkg::ST_A;
        end
      end
      cwc_pkg::ST_A: begin
        if (fall_edge) begin
          next_r.state = cwc_pkg::ST_FALL;
        end
      end
      cwc_pkg::ST_FALL: begin
        if (rise_edge) begin
          next_r.state = cwc_pkg::ST_RISE;
        end else if (fall_done) begin
          next_r.state = cwc_pkg::ST_B;
        end
      end
      cwc_pkg::ST_B: begin
        if (rise_edge) begin
          next_r.state = cwc_pkg::ST_RISE;
        end
      end
      default: begin
        next_r.state = cwc_pkg::ST_OFF;
      end
    endcase
    if (!enabled) begin
      next_r.state = cwc_pkg::ST_OFF;
    end else if (shut_req) begin
      next_r.state = cwc_pkg::ST_SHUT;
    end

    // pin levels follow the next state so they leave a flip-flop
    if (next_r.state == cwc_pkg::ST_SHUT) begin
      next_r.pa = next_r.shut[cwc_pkg::SHUT_OVR_A];
      next_r.pb = next_r.shut[cwc_pkg::SHUT_OVR_B];
    end else begin
      next_r.pa = (next_r.state == cwc_pkg::ST_A) ^
                  next_r.ctrl[cwc_pkg::CTRL_POLA];
      next_r.pb = (next_r.state == cwc_pkg::ST_B) ^
                  next_r.ctrl[cwc_pkg::CTRL_POLB];
    end
    next_r.pa_oe = next_r.ctrl[cwc_pkg::CTRL_OEA] &&
                   next_r.ctrl[cwc_pkg::CTRL_EN];
    next_r.pb_oe = next_r.ctrl[cwc_pkg::CTRL_OEB] &&
                   next_r.ctrl[cwc_pkg::CTRL_EN];
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.ctrl <= cwc_pkg::CTRL_RST;
      r.dbr <= cwc_pkg::DB_RST;
      r.dbf <= cwc_pkg::DB_RST;
      r.shut <= cwc_pkg::SHUT_RST;
      r.state <= cwc_pkg::ST_OFF;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign primary_output = r.pa;
  assign primary_output_oe = r.pa_oe;
  assign complementary_output = r.pb;
  assign complementary_output_oe = r.pb_oe;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_comp_pin_enable: assert property (
    (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == cwc_pkg::ADR_CTRL)
    |=> complementary_output_oe == ($past(wb_dat_i[6]) && $past(wb_dat_i[7])))
    else $error("complementary pin enable does not follow control write");

  a_prim_pin_enable: assert property (
    (bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == cwc_pkg::ADR_CTRL)
    |=> primary_output_oe == ($past(wb_dat_i[5]) && $past(wb_dat_i[7])))
    else $error("primary pin enable does not follow control write");

  a_prim_polarity: assert property (
    (r.state == cwc_pkg::ST_A)
    |-> primary_output != r.ctrl[cwc_pkg::CTRL_POLA]
      && complementary_output == r.ctrl[cwc_pkg::CTRL_POLB])
    else $error("primary active level wrong for its polarity");

  a_comp_polarity: assert property (
    (r.state == cwc_pkg::ST_B)
    |-> complementary_output != r.ctrl[cwc_pkg::CTRL_POLB]
      && primary_output == r.ctrl[cwc_pkg::CTRL_POLA])
    else $error("complementary active level wrong for its polarity");

  a_unused_bits_zero: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == cwc_pkg::ADR_CTRL)
    |-> wb_dat_o[2:1] == 2'h0 && r.ctrl[2:1] == 2'h0)
    else $error("control bits 2 and 1 not zero");

  a_deadband_wait: assert property (
    $rose(r.state == cwc_pkg::ST_A)
    |-> $past(r.state) == cwc_pkg::ST_RISE && $past(rise_done))
    else $error("primary output turned on without a finished dead band");

  a_override_level: assert property (
    (r.state == cwc_pkg::ST_SHUT)
    |-> primary_output == r.shut[cwc_pkg::SHUT_OVR_A]
      && complementary_output == r.shut[cwc_pkg::SHUT_OVR_B])
    else $error("shutdown pins do not show override levels");

  a_disable_off: assert property (
    !enabled |-> !primary_output_oe && !complementary_output_oe
      ##1 r.state == cwc_pkg::ST_OFF)
    else $error("generator runs while disabled");
endmodule

// ==== inc/cwc_pkg.sv ====
package cwc_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_DB_RISE = 8'h04;
  localparam logic [7:0] ADR_DB_FALL = 8'h08;
  localparam logic [7:0] ADR_SHUT = 8'h0C;
  localparam logic [7:0] ADR_STATUS = 8'h10;

  // waveform_control_zero field positions
  localparam int CTRL_EN = 7;
  localparam int CTRL_OEB = 6;
  localparam int CTRL_OEA = 5;
  localparam int CTRL_POLB = 4;
  localparam int CTRL_POLA = 3;
  localparam int CTRL_CS = 0;
  // writable bits of waveform_control_zero, bits 2 and 1 stay zero
  localparam logic [7:0] CTRL_MASK = 8'hF9;

  // shutdown control field positions
  localparam int SHUT_SW = 0;
  localparam int SHUT_OVR_A = 1;
  localparam int SHUT_OVR_B = 2;

  // dead-band count width
  localparam int DB_W = 6;

  // values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [DB_W-1:0] DB_RST = 6'h00;
  localparam logic [2:0] SHUT_RST = 3'h0;

  typedef enum logic [5:0] {
    ST_OFF = 6'h01,
    ST_SHUT = 6'h02,
    ST_RISE = 6'h04,
    ST_A = 6'h08,
    ST_FALL = 6'h10,
    ST_B = 6'h20
  } cwc_state_e;
endpackage

// ==== verilog/cwc_deadband.sv ====
`timescale 1ns/1ns
module cwc_deadband (
  input wire logic mclk, // system clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic start, // one-cycle pulse, restarts the interval
  input wire logic tick, // one period of the generator clock
  input wire logic [cwc_pkg::DB_W-1:0] limit, // programmed count
  output logic done // interval complete, one-cycle pulse
);
  typedef struct packed {
    logic busy;
    logic [cwc_pkg::DB_W-1:0] cnt;
  } cwc_db_s;

  cwc_db_s r;
  cwc_db_s next_r;

  assign done = r.busy && (r.cnt == limit);

  always_comb begin
    next_r = r;
    if (start) begin
      next_r.busy = 1'b1;
      next_r.cnt = '0;
    end else if (done) begin
      next_r.busy = 1'b0;
    end else if (r.busy && tick) begin
      next_r.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule

// ==== test/cwc_driver_model.sv ====
`timescale 1ns/1ns
// power switch stage: flags any cycle with both switches on
module cwc_driver_model (
  input wire logic mclk, // system clock
  input wire logic arm, // watch for overlap
  input wire logic a, // primary pin level
  input wire logic a_oe, // primary pin driven
  input wire logic a_inv, // primary active low
  input wire logic b, // complementary pin level
  input wire logic b_oe, // complementary pin driven
  input wire logic b_inv, // complementary active low
  output logic overlap // sticky shoot-through flag
);
  logic a_on;
  logic b_on;
  assign a_on = a_oe && (a ^ a_inv);
  assign b_on = b_oe && (b ^ b_inv);
  initial overlap = 1'b0;
  always @(posedge mclk) begin
    if (arm && a_on && b_on) begin
      overlap <= 1'b1;
    end
  end
endmodule

// ==== test/test_cwc_top.sv ====
`timescale 1ns/1ns
module test_cwc_top;
  logic mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0, src = 0;
  logic tick = 0, shut = 0, arm = 0, ovl;
  logic [7:0] adr = 8'h00, rd;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, dat_o;
  logic ack, pa, pa_oe, pb, pb_oe;
  int error_cnt = 0, checks = 0, cyc_cnt = 0, n;
  // ctrl, source level, expected {a_oe, a, b_oe, b}
  logic [15:0] rows [8] = '{16'hE01E, 16'hE00B, 16'hF81B, 16'hF80E,
                            16'hC003, 16'hA01C, 16'h6010, 16'hE80F};
  cwc_top u_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .source_in(src),
    .fast_osc_tick(tick), .shutdown_in(shut), .primary_output(pa),
    .primary_output_oe(pa_oe), .complementary_output(pb),
    .complementary_output_oe(pb_oe));
  cwc_driver_model u_drv (.mclk(mclk), .arm(arm), .a(pa), .a_oe(pa_oe),
    .a_inv(rd[3]), .b(pb), .b_oe(pb_oe), .b_inv(rd[4]), .overlap(ovl));
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic chk(input string name, input logic [7:0] got, exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, d,
                    output logic [7:0] r);
    int k;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= {24'h00_0000, d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    r = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 50) begin
      chk("ack", 8'h00, 8'h01);
    end
    @(posedge mclk);
  endtask
  task automatic waitn(input int c);
    repeat (c) @(negedge mclk);
  endtask
  initial begin
    logic [7:0] t;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    wb(0, cwc_pkg::ADR_CTRL, 8'h00, t);
    chk("ctrl_reset", t, cwc_pkg::CTRL_RST);
    wb(1, cwc_pkg::ADR_CTRL, 8'hFF, t);
    wb(0, cwc_pkg::ADR_CTRL, 8'h00, t);
    chk("ctrl_unused", t, 8'hF9);
    wb(0, 8'h14, 8'h00, t);
    chk("unmapped", t, 8'h00);
    for (int i = 0; i < 8; i++) begin
      arm <= 1'b0;
      wb(1, cwc_pkg::ADR_CTRL, rows[i][15:8], t);
      wb(0, cwc_pkg::ADR_CTRL, 8'h00, rd);
      src <= rows[i][4];
      arm <= 1'b1;
      waitn(10);
      chk("a_oe", pa_oe, rows[i][3]);
      chk("b_oe", pb_oe, rows[i][1]);
      if (rows[i][3]) chk("a_level", pa, rows[i][2]);
      if (rows[i][1]) chk("b_level", pb, rows[i][0]);
    end
    arm <= 1'b0;
    wb(1, cwc_pkg::ADR_DB_RISE, 8'h03, t);
    wb(0, cwc_pkg::ADR_DB_RISE, 8'h00, t);
    chk("dbr_read", t, 8'h03);
    wb(1, cwc_pkg::ADR_CTRL, 8'hE0, t);
    // keep the stage model's polarity view in step with the register
    wb(0, cwc_pkg::ADR_CTRL, 8'h00, rd);
    arm <= 1'b1;
    src <= 1'b0;
    waitn(12);
    @(posedge mclk);
    src <= 1'b1;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (pa !== 1'b1 && n < 40);
    chk("rise_delay", n[7:0], 8'h06);
    wb(1, cwc_pkg::ADR_DB_FALL, 8'h02, t);
    wb(1, cwc_pkg::ADR_CTRL, 8'hE1, t);
    src <= 1'b0;
    waitn(20);
    chk("b_no_tick", pb, 1'b0);
    repeat (10) begin
      @(posedge mclk);
      tick <= 1'b1;
      @(posedge mclk);
      tick <= 1'b0;
    end
    waitn(2);
    chk("b_ticked", pb, 1'b1);
    chk("overlap", ovl, 1'b0);
    arm <= 1'b0;
    wb(1, cwc_pkg::ADR_CTRL, 8'hF8, t);
    wb(1, cwc_pkg::ADR_SHUT, 8'h07, t);
    waitn(3);
    chk("ovr_high", {pa, pb}, 2'b11);
    wb(1, cwc_pkg::ADR_SHUT, 8'h01, t);
    waitn(3);
    chk("ovr_low", {pa, pb}, 2'b00);
    wb(1, cwc_pkg::ADR_SHUT, 8'h06, t);
    // leave shutdown on a rising source edge before the external request
    src <= 1'b1;
    waitn(8);
    chk("ovr_left", {pa, pb}, 2'b01);
    @(posedge mclk);
    shut <= 1'b1;
    waitn(3);
    chk("ovr_ext", {pa, pb}, 2'b11);
    wb(0, cwc_pkg::ADR_STATUS, 8'h00, t);
    chk("status", t, 8'hC2);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk("pins_reset", {pa_oe, pb_oe, pa, pb}, 4'h0);
    wb(0, cwc_pkg::ADR_CTRL, 8'h00, t);
    chk("ctrl_reset2", t, cwc_pkg::CTRL_RST);
    summarize();
  end
endmodule
